// ### rtl/srql_pkg.sv
// Shared constants, carrier types and frame helpers for the read-back and qualify logic
package srql_pkg;
   localparam int         FRAME_W       = 16;
   localparam int         ADDR_W        = 4;
   localparam int         DATA_W        = 10;
   localparam int         DIAG_W        = 4;
   localparam int         REV_W         = 6;
   localparam int         RW_POS        = 15;
   localparam int         ADDR_LSB      = 11;
   localparam int         PAR_POS       = 10;
   localparam int         DIAG_LEN      = 3;
   localparam int         DIAG_PAR      = 2;
   localparam int         DIAG_ACC      = 1;
   localparam int         DIAG_HWR      = 0;
   localparam logic [3:0] RW_DONE_CNT   = 4'h1;
   localparam logic [3:0] ADDR_DONE_CNT = 4'h5;
   localparam logic [3:0] LAST_BIT_CNT  = 4'hF;
   localparam logic [3:0] CHECK_PATTERN = 4'h9;

   typedef enum {LOG_INIT, LOG_WRITE, LOG_STD_READ, LOG_DC_READ, LOG_REJECT} srql_log_kind_t;

   // Pins from the link, sampled together through one synchroniser
   typedef struct packed {
      logic sclk;
      logic cs_n;
      logic sdi;
      logic hw_n;
   } srql_pins_t;

   // Command handed to the register file after a qualified transaction
   typedef struct packed {
      logic              read;
      logic              write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } srql_exec_t;

   typedef struct packed {
      logic              qualified;
      logic [DIAG_W-1:0] fail;
   } srql_verdict_t;

   function automatic logic out_parity(input logic [FRAME_W-2:0] info);
      return ~(^info);
   endfunction

   // Error flag, middle nibble, parity, data: odd parity over all sixteen bits
   function automatic logic [FRAME_W-1:0] make_frame(input logic              flag,
                                                     input logic [ADDR_W-1:0] mid,
                                                     input logic [DATA_W-1:0] data);
      return {flag, mid, out_parity({flag, mid, data}), data};
   endfunction
endpackage

// ### rtl/srql_sync.sv
// Two-stage synchroniser for the link pins
`timescale 1ns/1ps
module srql_sync
   import srql_pkg::*;
(
   input  wire logic       CLK,
   input  wire logic       SRST,
   input  wire srql_pins_t PINS_IN,
   output srql_pins_t      PINS_OUT
);
   typedef struct packed {
      srql_pins_t s1;
      srql_pins_t s2;
   } srql_sync_state_t;

   // Idle levels: clock low, select and reset released
   localparam srql_pins_t IDLE_PINS = '{sclk: 1'b0, cs_n: 1'b1, sdi: 1'b0, hw_n: 1'b1};

   srql_sync_state_t state_reg;
   srql_sync_state_t state_next;

   always_comb begin
      state_next    = state_reg;
      state_next.s1 = PINS_IN;
      state_next.s2 = state_reg.s1;
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         state_reg <= '{s1: IDLE_PINS, s2: IDLE_PINS};
      end else begin
         state_reg <= state_next;
      end
   end

   assign PINS_OUT = state_reg.s2;
endmodule // srql_sync

// ### rtl/srql_qualify.sv
// Qualification of the last received frame with ordered error selection
`timescale 1ns/1ps
module srql_qualify
   import srql_pkg::*;
#(
   parameter logic [FRAME_W-1:0] WRITABLE_MASK = 16'hFFFF
)
(
   input  wire logic [FRAME_W-1:0] FRAME,
   input  wire logic               LEN_OK,
   input  wire logic               RST_SEEN,
   output srql_verdict_t           VERDICT
);
   logic              par_ok;
   logic              is_read;
   logic [ADDR_W-1:0] addr;
   logic              access_bad;

   always_comb begin
      par_ok     = ^FRAME;
      is_read    = FRAME[RW_POS];
      addr       = FRAME[ADDR_LSB +: ADDR_W];
      access_bad = is_read ? (FRAME[DATA_W-1:0] != '0)
                           : (!WRITABLE_MASK[addr] || RST_SEEN);      // see [R16]
      VERDICT    = '0;
      // Only the first failing check is reported
      if (!LEN_OK) begin                                              // see [R17]
         VERDICT.fail[DIAG_LEN] = 1'b1;                               // see [R14]
      end else if (!par_ok) begin
         VERDICT.fail[DIAG_PAR] = 1'b1;                               // see [R15]
      end else if (access_bad) begin
         VERDICT.fail[DIAG_ACC] = 1'b1;
      end
      VERDICT.qualified = (VERDICT.fail == '0);                       // see [R10]
   end
endmodule // srql_qualify

// ### rtl/spi_readback_qualify_log.sv
// SPI target read path: SDO answer, pass-through, qualification and transaction log
//
// Overview of operation
// [R1] Standard mode answers a read with error flag, status, parity, ten data bits.
// [R2] Later frames of a transaction replay received SDI frames, sixteen clocks late.
// [R3] Standard mode samples register data once the four address bits arrive.
// [R4] Daisy-chain mode sends the current transaction log in the first frame.
// [R5] Daisy chain executes only the last frame; read data comes next transaction.
// [R6] Daisy-chain SDO content is the same for reads and writes.
// [R7] Daisy-chain read data is sampled at the start of the following transaction.
// [R8] SDO bit ten is inverted XOR of the other fifteen bits: odd parity.
// [R9] Master checks a returned frame by XOR of all sixteen bits giving one.
// [R10] A read qualifies on length multiple of sixteen, odd parity, zero data.
// [R11] Qualified read executes, triggers clear-on-read and loads the log.
// [R12] Failed read is not executed; sets error flag, diagnostic bit, logs failure.
// [R13] Any unqualified transaction sets the error flag, reported afterwards.
// [R14] Length error bit rises when the clock count is not a sixteen multiple.
// [R15] Parity error bit rises when the received frame fails odd parity.
// [R16] Access error: bad write address, write under reset, or nonzero read data.
// [R17] Only the highest error is recorded: length, then parity, then access.
// [R18] Diagnostic bits accumulate and clear only on a qualified config read.
// [R19] Later transactions qualify and log normally while diagnostic bits stay set.
// [R20] Log updates on chip-select rise according to direction, result, mode, select.
// [R21] Daisy read log: flag, address or status, parity, register data.
// [R22] Standard read log: flag, address, parity, current device status.
// [R23] Rejected log: flag one, parity, cumulative error bits nine to six.
// [R24] Initial log: flag zero, zero address, parity, revision code, check pattern.
// [R25] Count clocks within chip select and keep the last sixteen bits received.
`timescale 1ns/1ps
module spi_readback_qualify_log
   import srql_pkg::*;
#(
   parameter logic [ADDR_W-1:0]  CONFIG_REG_ADDR = 4'h0,
   parameter logic [FRAME_W-1:0] WRITABLE_MASK   = 16'hFFFF,
   // Arbitrary neutral value
   parameter logic [REV_W-1:0]   REVISION_CODE   = 6'h15
)
(
   input  wire logic              CLK,
   input  wire logic              SRST,
   input  wire logic              SCLK,
   input  wire logic              CHIP_SELECT_LOW_N,
   input  wire logic              SDI,
   output logic                   SDO,
   output logic                   SDO_OE,
   input  wire logic              HARDWARE_RESET_INPUT_N,
   input  wire logic              DAISY_CHAIN_ENABLE,
   input  wire logic              STATUS_OR_ADDRESS_SELECT,
   input  wire logic [ADDR_W-1:0] GENERAL_STATUS_BITS,
   input  wire logic [DATA_W-1:0] DEVICE_STATUS,
   output logic [ADDR_W-1:0]      REG_RD_ADDR,
   output logic                   REG_RD_SAMPLE,
   input  wire logic [DATA_W-1:0] REG_RD_DATA,
   output srql_exec_t             EXEC,
   output logic                   INTERFACE_ERROR,
   output logic [DIAG_W-1:0]      DIAG_BITS
);
   // Writable mask needs one bit for every address
   if (FRAME_W != 2 ** ADDR_W) begin : g_param_check
      $error("writable mask must hold one bit per address");
   end

   typedef struct packed {
      logic               sclk_q;
      logic               cs_n_q;
      logic               active;
      logic [3:0]         bit_cnt;
      logic               any_clk;
      logic               past_first;
      logic [FRAME_W-1:0] rx_shift;
      logic [FRAME_W-1:0] frame_word;
      logic               std_read;
      logic               fetch_log;
      logic               fetch_std;
      logic               rst_in_txn;
      logic               interface_error;
      logic [DIAG_W-1:0]  diag;
      srql_log_kind_t     log_kind;
      logic [ADDR_W-1:0]  log_addr;
      logic [DATA_W-1:0]  log_data;
      logic               sdo;
      logic               sdo_oe;
      logic [ADDR_W-1:0]  rd_addr;
      logic               rd_sample;
      srql_exec_t         exec;
   } srql_state_t;

   srql_state_t   state_reg;
   srql_state_t   state_next;
   srql_pins_t    pins_raw;
   srql_pins_t    pins_s;
   srql_verdict_t verdict;
   logic          sclk_rise;
   logic          sclk_fall;
   logic          cs_fall;
   logic          cs_rise;
   logic          len_ok;
   logic [FRAME_W-1:0] log_word;

   assign pins_raw = '{sclk: SCLK, cs_n: CHIP_SELECT_LOW_N, sdi: SDI,
                       hw_n: HARDWARE_RESET_INPUT_N};

   // Every link pin crosses here; nothing reads the raw pins
   srql_sync u_sync (
      .CLK      (CLK),
      .SRST     (SRST),
      .PINS_IN  (pins_raw),
      .PINS_OUT (pins_s)
   );

   // Edges of the link clock and select, found on the synchronised copies
   assign sclk_rise = pins_s.sclk && !state_reg.sclk_q;
   assign sclk_fall = !pins_s.sclk && state_reg.sclk_q;
   assign cs_fall   = !pins_s.cs_n && state_reg.cs_n_q;
   assign cs_rise   = pins_s.cs_n && !state_reg.cs_n_q;
   // Counter wraps every sixteen rises: zero after clocks means whole frames
   assign len_ok    = state_reg.any_clk && (state_reg.bit_cnt == '0);

   srql_qualify #(
      .WRITABLE_MASK (WRITABLE_MASK)
   ) u_qualify (
      .FRAME    (state_reg.rx_shift),
      .LEN_OK   (len_ok),
      .RST_SEEN (state_reg.rst_in_txn),
      .VERDICT  (verdict)
   );

   // Log word is rebuilt when sent, so flag, status and read data are current
   always_comb begin
      case (state_reg.log_kind)
         LOG_INIT: begin
            log_word = make_frame(1'b0, '0, {REVISION_CODE, CHECK_PATTERN});     // see [R24]
         end
         LOG_WRITE: begin
            log_word = make_frame(state_reg.interface_error, state_reg.log_addr,
                                  state_reg.log_data);
         end
         LOG_STD_READ: begin
            log_word = make_frame(state_reg.interface_error, state_reg.log_addr,
                                  DEVICE_STATUS);                                // see [R22]
         end
         LOG_DC_READ: begin
            log_word = make_frame(state_reg.interface_error,
                                  STATUS_OR_ADDRESS_SELECT ? GENERAL_STATUS_BITS
                                                           : state_reg.log_addr,
                                  REG_RD_DATA);                                  // see [R21]
         end
         LOG_REJECT: begin
            log_word = make_frame(1'b1, '0,
                                  {state_reg.diag, {(DATA_W - DIAG_W){1'b0}}});  // see [R23]
         end
         default: begin
            log_word = '0;
         end
      endcase
   end

   always_comb begin
      logic [FRAME_W-1:0] rx_next;
      logic [3:0]         cnt_next;
      rx_next  = {state_reg.rx_shift[FRAME_W-2:0], pins_s.sdi};
      cnt_next = state_reg.bit_cnt + 4'h1;
      state_next           = state_reg;
      state_next.sclk_q    = pins_s.sclk;
      state_next.cs_n_q    = pins_s.cs_n;
      state_next.fetch_log = 1'b0;
      state_next.fetch_std = 1'b0;
      state_next.rd_sample = 1'b0;
      state_next.exec      = '0;

      if (cs_fall) begin
         state_next.active     = 1'b1;
         state_next.bit_cnt    = '0;                                   // see [R25]
         state_next.any_clk    = 1'b0;
         state_next.past_first = 1'b0;
         state_next.std_read   = 1'b0;
         state_next.rst_in_txn = 1'b0;
         state_next.sdo_oe     = 1'b1;
         state_next.fetch_log  = 1'b1;                                 // see [R4]
         state_next.rd_addr    = state_reg.log_addr;
         // Daisy read data is fetched now, not when the read executed
         state_next.rd_sample  = (state_reg.log_kind == LOG_DC_READ);  // see [R7]
      end else if (cs_rise && state_reg.active) begin
         state_next.active = 1'b0;
         state_next.sdo_oe = 1'b0;
         state_next.sdo    = 1'b0;
         // A select pulse with no clocks is ignored and leaves the log alone
         if (state_reg.any_clk) begin                                  // see [R20]
            if (verdict.qualified) begin                               // see [R19]
               // Only the last sixteen bits form the command
               state_next.exec.addr = state_reg.rx_shift[ADDR_LSB +: ADDR_W];   // see [R5]
               state_next.exec.data = state_reg.rx_shift[DATA_W-1:0];
               state_next.log_addr  = state_reg.rx_shift[ADDR_LSB +: ADDR_W];
               if (state_reg.rx_shift[RW_POS]) begin
                  state_next.exec.read = 1'b1;                         // see [R11]
                  state_next.log_kind  = DAISY_CHAIN_ENABLE ? LOG_DC_READ : LOG_STD_READ;
                  if (state_reg.rx_shift[ADDR_LSB +: ADDR_W] == CONFIG_REG_ADDR) begin
                     state_next.diag            = '0;                  // see [R18]
                     state_next.interface_error = 1'b0;
                  end
               end else begin
                  state_next.exec.write = 1'b1;
                  state_next.log_kind   = LOG_WRITE;
                  state_next.log_data   = state_reg.rx_shift[DATA_W-1:0];
               end
            end else begin
               // Flag stays set until a qualified config read clears it
               state_next.interface_error = 1'b1;                      // see [R13]
               state_next.diag            = state_reg.diag | verdict.fail;   // see [R12]
               state_next.log_kind        = LOG_REJECT;
            end
         end
      end else if (state_reg.active) begin
         if (sclk_rise) begin
            state_next.rx_shift = rx_next;                             // see [R25]
            state_next.bit_cnt  = cnt_next;
            state_next.any_clk  = 1'b1;
            if (state_reg.bit_cnt == LAST_BIT_CNT) begin
               state_next.past_first = 1'b1;
            end
            // Direct answer only in the first frame of a standard-mode read
            if (!state_reg.past_first && !DAISY_CHAIN_ENABLE) begin
               if (cnt_next == RW_DONE_CNT && pins_s.sdi) begin
                  state_next.std_read = 1'b1;
                  state_next.frame_word[FRAME_W-1:ADDR_LSB] =
                     {state_reg.interface_error, GENERAL_STATUS_BITS};  // see [R1]
               end
               if (cnt_next == ADDR_DONE_CNT && state_reg.std_read) begin
                  state_next.rd_addr   = rx_next[ADDR_W-1:0];          // see [R3]
                  state_next.rd_sample = 1'b1;
                  state_next.fetch_std = 1'b1;
               end
            end
         end
         if (sclk_fall && state_reg.any_clk) begin
            if (state_reg.bit_cnt == '0) begin
               // Frame boundary: replay the frame just received, unaltered
               state_next.frame_word = state_reg.rx_shift;             // see [R2]
               state_next.sdo        = state_reg.rx_shift[FRAME_W-1];
            end else begin
               state_next.sdo = state_reg.frame_word[LAST_BIT_CNT - state_reg.bit_cnt];
            end
         end
      end

      if (state_reg.fetch_log) begin
         // Same log path for reads and writes in daisy mode
         state_next.frame_word = log_word;                             // see [R6]
         state_next.sdo        = log_word[FRAME_W-1];
      end
      // Read data is taken in the same cycle as the sample pulse, long before bit ten leaves
      if (state_reg.fetch_std) begin
         state_next.frame_word = make_frame(state_reg.frame_word[FRAME_W-1],
                                            state_reg.frame_word[ADDR_LSB +: ADDR_W],
                                            REG_RD_DATA);              // see [R8]
      end
      // Reset seen wins over a clear in the same cycle
      if (!pins_s.hw_n) begin
         state_next.diag[DIAG_HWR] = 1'b1;
         if (state_reg.active) begin
            state_next.rst_in_txn = 1'b1;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         state_reg          <= '0;
         // Select idles high, so leaving reset gives no false falling edge
         state_reg.cs_n_q   <= 1'b1;
         state_reg.log_kind <= LOG_INIT;
      end else begin
         state_reg <= state_next;
      end
   end

   assign SDO             = state_reg.sdo;
   assign SDO_OE          = state_reg.sdo_oe;
   assign REG_RD_ADDR     = state_reg.rd_addr;
   assign REG_RD_SAMPLE   = state_reg.rd_sample;
   assign EXEC            = state_reg.exec;
   assign INTERFACE_ERROR = state_reg.interface_error;
   assign DIAG_BITS       = state_reg.diag;

   logic end_valid;
   assign end_valid = cs_rise && state_reg.active && state_reg.any_clk;

   chk_log_parity: assert property (@(posedge CLK) disable iff (SRST)   // see [R8]
      state_reg.fetch_log |=> (^state_reg.frame_word) && state_reg.sdo == state_reg.frame_word[15])
      else $error("log frame sent without odd parity");

   chk_frame_replay: assert property (@(posedge CLK) disable iff (SRST) // see [R2]
      (state_reg.active && !cs_rise && !cs_fall && sclk_fall && len_ok)
      |=> state_reg.frame_word == $past(state_reg.rx_shift) && state_reg.sdo == state_reg.frame_word[15])
      else $error("received frame not replayed at frame boundary");

   chk_len_error: assert property (@(posedge CLK) disable iff (SRST)    // see [R14]
      (end_valid && state_reg.bit_cnt != 4'h0)
      |=> DIAG_BITS[DIAG_LEN] && INTERFACE_ERROR && state_reg.log_kind == LOG_REJECT)
      else $error("short transaction not flagged as length error");

   chk_err_order: assert property (@(posedge CLK) disable iff (SRST)    // see [R17]
      (end_valid && !len_ok) |=> $stable(DIAG_BITS[DIAG_PAR]) && $stable(DIAG_BITS[DIAG_ACC]))
      else $error("lower error recorded beside length error");

   chk_par_error: assert property (@(posedge CLK) disable iff (SRST)    // see [R15]
      (end_valid && len_ok && !(^state_reg.rx_shift)) |=> DIAG_BITS[DIAG_PAR] && !EXEC.read)
      else $error("parity failure not recorded");

   chk_read_exec: assert property (@(posedge CLK) disable iff (SRST)    // see [R11]
      (end_valid && verdict.qualified && state_reg.rx_shift[15])
      |=> EXEC.read ##1 !EXEC.read)
      else $error("qualified read not executed as one pulse");

   chk_reject_noexec: assert property (@(posedge CLK) disable iff (SRST) // see [R12]
      (end_valid && !verdict.qualified)
      |=> !EXEC.read && !EXEC.write && INTERFACE_ERROR
          && ((DIAG_BITS & $past(verdict.fail)) == $past(verdict.fail)))
      else $error("rejected transaction executed or not recorded");

   chk_std_sample: assert property (@(posedge CLK) disable iff (SRST)   // see [R3]
      (state_reg.active && sclk_rise && !cs_rise && !state_reg.past_first && !DAISY_CHAIN_ENABLE
       && state_reg.std_read && state_reg.bit_cnt == 4'h4)
      |=> REG_RD_SAMPLE ##1 (state_reg.frame_word[9:0] == $past(REG_RD_DATA)))
      else $error("standard read data not sampled after address");

   chk_diag_sticky: assert property (@(posedge CLK) disable iff (SRST)  // see [R18]
      !(end_valid && verdict.qualified) |=> (DIAG_BITS & $past(DIAG_BITS)) == $past(DIAG_BITS))
      else $error("diagnostic bit dropped without config read");

   chk_sdo_enable: assert property (@(posedge CLK) disable iff (SRST)   // see [R4]
      cs_fall |=> SDO_OE ##1 state_reg.frame_word == $past(log_word))
      else $error("log not loaded at start of transaction");

   cov_daisy_read: cover property (@(posedge CLK) disable iff (SRST)
      end_valid && verdict.qualified && state_reg.rx_shift[15] && DAISY_CHAIN_ENABLE);
   cov_std_read: cover property (@(posedge CLK) disable iff (SRST)
      state_reg.fetch_std);
   cov_reject: cover property (@(posedge CLK) disable iff (SRST)
      end_valid && !verdict.qualified);
   cov_replay: cover property (@(posedge CLK) disable iff (SRST)
      state_reg.past_first && sclk_fall && len_ok);

   cov_qualify_after_err: cover property (@(posedge CLK) disable iff (SRST)
      end_valid && verdict.qualified && state_reg.diag != '0);
endmodule // spi_readback_qualify_log

// ### testbench/srql_spi_master.sv
// Mode 0 master model on the link pins
`timescale 1ns/1ps
module srql_spi_master (
   input  wire logic clk,
   input  wire logic sdo,
   output logic      sclk,
   output logic      cs_n,
   output logic      sdi
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      sdi  = 1'b0;
   end
   // Sends tx MSB first; SDO sampled late in the high phase, long after it moved
   task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
      rx = 32'h0;
      cs_n = 1'b0;
      repeat (8) @(negedge clk);
      for (int i = 0; i < n; i++) begin
         sdi = tx[31-i];
         repeat (4) @(negedge clk);
         sclk = 1'b1;
         repeat (4) @(negedge clk);
         rx = {rx[30:0], sdo};
         sclk = 1'b0;
      end
      rx = rx << (32 - n);
      repeat (4) @(negedge clk);
      cs_n = 1'b1;
      // Released line must not keep its last value
      sdi = ~sdi;
      repeat (12) @(negedge clk);
   endtask
endmodule // srql_spi_master

// ### testbench/spi_readback_qualify_log_tb_top.sv
// Self-checking bench for the read-back, qualify and log block
`timescale 1ns/1ps
module spi_readback_qualify_log_tb_top
   import srql_pkg::*;
;
   localparam logic [REV_W-1:0] REV_TB = 6'h2A; // Arbitrary value
   logic        clk, srst, sclk, cs_n, sdi, sdo, hw_n, daisy, sel, err, oe, rdsmp;
   logic [3:0]  st, rd_addr, diag, dexp, a, b;
   logic [9:0]  dstat, d;
   logic [31:0] rx;
   logic [15:0] logx;
   srql_exec_t  exec, exec_seen;
   int          miscompares, check_count, exec_base, smp_base, oe_base;
   int          n_exec = 0, n_smp = 0, n_oe = 0;
   logic [31:0] etx [3];
   int          elen [3] = '{17, 16, 16};
   logic [3:0]  emask [3] = '{4'h8, 4'h4, 4'h2};

   function automatic logic [15:0] frm(input logic f, input logic [3:0] m, input logic [9:0] v);
      return {f, m, ~^{f, m, v}, v};
   endfunction
   function automatic logic [9:0] regv(input logic [3:0] x);
      return {x, ~x, 2'h1} ^ 10'h2C5;
   endfunction

   spi_readback_qualify_log #(.REVISION_CODE(REV_TB)) i_spi_readback_qualify_log (
      .CLK(clk), .SRST(srst), .SCLK(sclk), .CHIP_SELECT_LOW_N(cs_n), .SDI(sdi),
      .SDO(sdo), .SDO_OE(oe), .HARDWARE_RESET_INPUT_N(hw_n), .DAISY_CHAIN_ENABLE(daisy),
      .STATUS_OR_ADDRESS_SELECT(sel), .GENERAL_STATUS_BITS(st), .DEVICE_STATUS(dstat),
      .REG_RD_ADDR(rd_addr), .REG_RD_SAMPLE(rdsmp), .REG_RD_DATA(regv(rd_addr)), .EXEC(exec),
      .INTERFACE_ERROR(err), .DIAG_BITS(diag));
   srql_spi_master i_srql_spi_master (.clk(clk), .sdo(sdo), .sclk(sclk), .cs_n(cs_n), .sdi(sdi));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (exec.read | exec.write) begin
         exec_seen <= exec;
         n_exec <= n_exec + 1;
      end
      if (rdsmp) begin
         n_smp <= n_smp + 1;
      end
      if (oe) begin
         n_oe <= n_oe + 1;
      end
   end

   task automatic complete_run();
      if (miscompares == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic chk_exec(input logic rd, input logic [3:0] ad, input logic [9:0] dv);
      chk({6'(n_exec - exec_base), exec_seen.data}, {6'h01, dv});
      chk({10'h0, exec_seen.read, exec_seen.write, exec_seen.addr}, {10'h0, rd, ~rd, ad});
   endtask
   task automatic run(input logic [31:0] tx, input int n, input int smp);
      exec_base = n_exec;
      smp_base = n_smp;
      oe_base = n_oe;
      i_srql_spi_master.xfer(tx, n, rx);
      chk({15'h0, ^rx[31:16]}, 16'h0001);
      chk({8'(n_smp - smp_base), 7'h0, oe}, {8'(smp), 7'h0, 1'b0});
      chk({15'h0, n_oe > oe_base}, 16'h0001);
   endtask

   initial begin
      srst = 1'b1;
      hw_n = 1'b1;
      daisy = 1'b0;
      sel = 1'b1;
      st = 4'h0;
      dstat = 10'h0;
      miscompares = 0;
      check_count = 0;
      void'($urandom(62));
      fork
         begin
            repeat (20000) @(posedge clk);
            miscompares++;
            $display("unexpected at %0t: run did not finish in time", $time);
         end
         begin
            repeat (6) @(negedge clk);
            srst = 1'b0;
            d = 10'($urandom);
            run({frm(1'b0, 4'h5, d), 16'h0}, 16, 0);
            chk(rx[31:16], frm(1'b0, 4'h0, {REV_TB, 4'h9}));
            chk_exec(1'b0, 4'h5, d);
            for (int k = 0; k < 3; k++) begin
               a = 4'($urandom);
               st = 4'($urandom);
               dstat = 10'($urandom);
               run({frm(1'b1, a, 10'h0), frm(1'b1, a, 10'h0)}, 32, 1);
               chk(rx[31:16], frm(1'b0, st, regv(a)));
               chk(rx[15:0], frm(1'b1, a, 10'h0));
               chk_exec(1'b1, a, 10'h0);
            end
            b = a;
            a = 4'($urandom);
            daisy = 1'b1;
            run({frm(1'b1, a, 10'h0), 16'h0}, 16, 0);
            chk(rx[31:16], frm(1'b0, b, dstat));
            chk_exec(1'b1, a, 10'h0);
            d = 10'($urandom);
            run({frm(1'b0, 4'h7, d), 16'h0}, 16, 1);
            chk(rx[31:16], frm(1'b0, st, regv(a)));
            chk_exec(1'b0, 4'h7, d);
            // Length case: its last sixteen bits form a write that passes parity and access, so only length fails
            etx[0] = {frm(1'b1, 4'h3, 10'h3FF), 16'hFFFF};
            etx[1] = {frm(1'b1, 4'h2, 10'h001) ^ 16'h0400, 16'h0};
            etx[2] = {frm(1'b1, 4'h2, 10'h001), 16'h0};
            logx = frm(1'b0, 4'h7, d);
            dexp = 4'h0;
            for (int k = 0; k < 3; k++) begin
               run(etx[k], elen[k], 0);
               chk(rx[31:16], logx);
               dexp = dexp | emask[k];
               chk({11'h0, err, diag}, {11'h0, 1'b1, dexp});
               chk(16'(n_exec - exec_base), 16'h0);
               logx = frm(1'b1, 4'h0, {dexp, 6'h0});
            end
            run({frm(1'b1, 4'h0, 10'h0), 16'h0}, 16, 0);
            chk(rx[31:16], logx);
            chk({11'h0, err, diag}, 16'h0);
            chk_exec(1'b1, 4'h0, 10'h0);
            hw_n = 1'b0;
            repeat (4) @(negedge clk);
            hw_n = 1'b1;
            repeat (4) @(negedge clk);
            chk({12'h0, diag}, 16'h0001);
         end
      join_any
      disable fork;
      complete_run();
   end
endmodule // spi_readback_qualify_log_tb_top
